// [rtl/status_pkg.sv]
package status_pkg;

	// ------------------------------------------------------------
	// Widths, bit positions and preset values
	// ------------------------------------------------------------
	localparam int          REG_W           = 16;
	localparam int          STD_W           = 8;
	localparam int          QUEUE_DEPTH     = 16;
	localparam int          QUEUE_AW        = 4;
	localparam int          STB_OPERATION_SUMMARY        = 7;
	localparam int          STB_SRQ         = 6;
	localparam int          STB_STD         = 5;
	localparam int          STB_MAV         = 4;
	localparam int          STB_QUESTIONABLE_SUMMARY        = 3;
	localparam int          QUESTIONABLE_SUMMARY_OV         = 0;
	localparam logic [15:0] OPERATION_SUMMARY_RISE_PRESET = 16'h001F;
	localparam logic [15:0] QUESTIONABLE_SUMMARY_RISE_PRESET = 16'h0E3F;
	localparam logic [15:0] CLEAR_WORD       = 16'h0000;
	localparam logic [7:0]  STD_DEFINED      = 8'hBD;
	localparam logic [7:0]  CLEAR_BYTE       = 8'h00;
	localparam logic [15:0] OVP_LEVEL_RESET  = 16'hFFFF;
	localparam logic [4:0]  QUEUE_EMPTY      = 5'h00;
	localparam logic [4:0]  QUEUE_FULL       = 5'h10;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		RD_OPERATION_SUMMARY_COND, RD_OPERATION_SUMMARY_EVENT, WR_OPERATION_SUMMARY_ENABLE, RD_OPERATION_SUMMARY_ENABLE,
		WR_OPERATION_SUMMARY_FALL, RD_OPERATION_SUMMARY_FALL, WR_OPERATION_SUMMARY_RISE, RD_OPERATION_SUMMARY_RISE,
		RD_QUESTIONABLE_SUMMARY_COND, RD_QUESTIONABLE_SUMMARY_EVENT, WR_QUESTIONABLE_SUMMARY_ENABLE, RD_QUESTIONABLE_SUMMARY_ENABLE,
		WR_QUESTIONABLE_SUMMARY_FALL, RD_QUESTIONABLE_SUMMARY_FALL, WR_QUESTIONABLE_SUMMARY_RISE, RD_QUESTIONABLE_SUMMARY_RISE,
		RD_STD_EVENT, WR_STD_ENABLE, RD_STD_ENABLE, WR_SRQ_ENABLE,
		RD_SRQ_ENABLE, RD_STATUS_BYTE, STATUS_PRESET, CLEAR_STATUS,
		COUPLED_PROTECTION_FLAG_CLEAR, WR_OVP_LEVEL, RD_QUEUE
	} cmd_e;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		cmd_e        code;
		logic [15:0] data;
	} cmd_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} resp_s;

	typedef struct packed {
		logic transient_awaiting_trigger;
		logic measure_awaiting_trigger;
		logic output_off;
		logic constant_current_flag;
		logic constant_voltage_flag;
	} operation_summary_cond_s;

	typedef struct packed {
		logic coupled_protection_flag;
		logic unregulated_flag;
		logic inhibited_flag;
		logic negative_power_limit_flag;
		logic overtemperature_flag;
		logic positive_power_limit_flag;
		logic power_fail_flag;
		logic overcurrent_flag;
	} questionable_summary_cond_s;

endpackage

// [rtl/instrument_status_reporting.sv]
`timescale 1ns/100ps
// Function
// - Operation, questionable and standard event groups exist
// - Status bit 7 ORs enabled operation events
// - Status bit 3 ORs enabled questionable events
// - Standard events latch; read clears all bits except events arriving in the same cycle
// - Standard enable gates events into summary bit
// - Master summary is live OR of enabled bits
// - Status query returns master summary, clears nothing
// - Service request latches flag, drives request line
// - Serial poll returns flag, clears only it
// - Output queue sets message available when nonempty
// - Preset sets rising filters, clears others
// - Preset values 31 and 3647, rest zero
// - Operation events latch filtered edges, read clears
// - Operation bits 4 and 3 await triggers
// - Operation bits 2,1,0 off, current, voltage
// - Overvoltage trips output; clear only once gone
// - Rising/falling filter bits choose latched edges
// - Questionable bit map fixed, others undefined
// - Questionable event read returns then clears
// - Clear status empties events and request flag; MAV bit kept
module instrument_status_reporting (
	input  wire logic                   clk_in,
	input  wire logic                   reset_n_in,
	input  wire status_pkg::cmd_s       cmd_in,
	output status_pkg::resp_s           resp_out,
	input  wire status_pkg::operation_summary_cond_s operation_summary_cond_in,
	input  wire status_pkg::questionable_summary_cond_s questionable_summary_cond_in,
	input  wire logic [15:0]            output_voltage_in,
	input  wire logic [7:0]             std_event_in,
	input  wire logic                   queue_push_in,
	input  wire logic [7:0]             queue_data_in,
	output logic                        queue_ready_out,
	input  wire logic                   serial_poll_in,
	output logic [7:0]                  poll_byte_out,
	output logic                        service_request_out,
	output logic                        output_disable_out,
	output logic [7:0]                  status_byte_out
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] edge_events(
		input logic [15:0] cond,
		input logic [15:0] prev,
		input logic [15:0] rise,
		input logic [15:0] fall
	);
		edge_events = (cond & ~prev & rise) | (~cond & prev & fall);
	endfunction

	function automatic logic is_cmd(input status_pkg::cmd_s c, input status_pkg::cmd_e k);
		is_cmd = c.valid && (c.code == k);
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] operation_condition;
	logic [15:0] operation_event_latch;
	logic [15:0] operation_event_mask;
	logic [15:0] operation_fall_filter;
	logic [15:0] operation_rise_filter;
	logic [15:0] operation_summary_prev;
	logic [15:0] questionable_summary_condition;
	logic [15:0] questionable_summary_event_latch;
	logic [15:0] questionable_summary_event_mask;
	logic [15:0] questionable_summary_fall_filter;
	logic [15:0] questionable_summary_rise_filter;
	logic [15:0] questionable_summary_prev;
	logic [7:0]  std_event_latch;
	logic [7:0]  std_event_mask;
	logic [7:0]  srq_enable;
	logic [15:0] ovp_level;
	logic        overvoltage_protection;
	logic        request_service_latched;
	logic        mss_prev;
	logic [7:0]  queue_mem [status_pkg::QUEUE_DEPTH];
	logic [3:0]  queue_head;
	logic [3:0]  queue_tail;
	logic [4:0]  queue_count;
	logic [7:0]  summary_status_byte;
	logic        operation_summary;
	logic        questionable_summary;
	logic        std_summary;
	logic        message_available;
	logic        master_summary;
	logic        over_level;
	logic        do_pop;
	logic        do_push;
	logic        cls;
	logic        preset;
	logic [15:0] operation_summary_new;
	logic [15:0] questionable_summary_new;

	// ------------------------------------------------------------
	// Condition assembly
	// ------------------------------------------------------------
	assign over_level = output_voltage_in > ovp_level;
	always_comb
	begin
		operation_condition = {11'h000, operation_summary_cond_in};
		questionable_summary_condition = {4'h0, questionable_summary_cond_in.coupled_protection_flag, questionable_summary_cond_in.unregulated_flag,
			questionable_summary_cond_in.inhibited_flag, 3'h0, questionable_summary_cond_in.negative_power_limit_flag,
			questionable_summary_cond_in.overtemperature_flag, questionable_summary_cond_in.positive_power_limit_flag,
			questionable_summary_cond_in.power_fail_flag, questionable_summary_cond_in.overcurrent_flag,
			overvoltage_protection};
	end

	assign cls    = is_cmd(cmd_in, status_pkg::CLEAR_STATUS);
	assign preset = is_cmd(cmd_in, status_pkg::STATUS_PRESET);
	assign operation_summary_new = edge_events(operation_condition, operation_summary_prev,
		operation_rise_filter, operation_fall_filter);
	assign questionable_summary_new = edge_events(questionable_summary_condition, questionable_summary_prev, questionable_summary_rise_filter, questionable_summary_fall_filter);

	// ------------------------------------------------------------
	// Overvoltage protection
	// ------------------------------------------------------------
	// Clear ignored while still over level, so a trip cannot be lost
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			overvoltage_protection <= 1'b0;
		else if (over_level)
			overvoltage_protection <= 1'b1;
		else if (is_cmd(cmd_in, status_pkg::COUPLED_PROTECTION_FLAG_CLEAR))
			overvoltage_protection <= 1'b0;

	assign output_disable_out = overvoltage_protection;

	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			ovp_level <= status_pkg::OVP_LEVEL_RESET;
		else if (is_cmd(cmd_in, status_pkg::WR_OVP_LEVEL))
			ovp_level <= cmd_in.data;

	// ------------------------------------------------------------
	// Transition tracking and event latches
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			operation_summary_prev <= status_pkg::CLEAR_WORD;
			questionable_summary_prev <= status_pkg::CLEAR_WORD;
		end
		else
		begin
			operation_summary_prev <= operation_condition;
			questionable_summary_prev <= questionable_summary_condition;
		end

	// New edges win over a read or clear in the same cycle
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			operation_event_latch <= status_pkg::CLEAR_WORD;
			questionable_summary_event_latch <= status_pkg::CLEAR_WORD;
			std_event_latch <= status_pkg::CLEAR_BYTE;
		end
		else
		begin
			if (cls || is_cmd(cmd_in, status_pkg::RD_OPERATION_SUMMARY_EVENT))
				operation_event_latch <= operation_summary_new;
			else
				operation_event_latch <= operation_event_latch | operation_summary_new;
			if (cls || is_cmd(cmd_in, status_pkg::RD_QUESTIONABLE_SUMMARY_EVENT))
				questionable_summary_event_latch <= questionable_summary_new;
			else
				questionable_summary_event_latch <= questionable_summary_event_latch | questionable_summary_new;
			if (cls || is_cmd(cmd_in, status_pkg::RD_STD_EVENT))
				std_event_latch <= std_event_in & status_pkg::STD_DEFINED;
			else
				std_event_latch <= std_event_latch | (std_event_in & status_pkg::STD_DEFINED);
		end

	// ------------------------------------------------------------
	// Enable and filter registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			operation_event_mask <= status_pkg::CLEAR_WORD;
			operation_fall_filter <= status_pkg::CLEAR_WORD;
			operation_rise_filter <= status_pkg::OPERATION_SUMMARY_RISE_PRESET;
			questionable_summary_event_mask <= status_pkg::CLEAR_WORD;
			questionable_summary_fall_filter <= status_pkg::CLEAR_WORD;
			questionable_summary_rise_filter <= status_pkg::QUESTIONABLE_SUMMARY_RISE_PRESET;
		end
		else if (preset)
		begin
			operation_event_mask <= status_pkg::CLEAR_WORD;
			operation_fall_filter <= status_pkg::CLEAR_WORD;
			operation_rise_filter <= status_pkg::OPERATION_SUMMARY_RISE_PRESET;
			questionable_summary_event_mask <= status_pkg::CLEAR_WORD;
			questionable_summary_fall_filter <= status_pkg::CLEAR_WORD;
			questionable_summary_rise_filter <= status_pkg::QUESTIONABLE_SUMMARY_RISE_PRESET;
		end
		else if (cmd_in.valid)
		begin
			unique case (cmd_in.code)
				status_pkg::WR_OPERATION_SUMMARY_ENABLE: operation_event_mask <= cmd_in.data;
				status_pkg::WR_OPERATION_SUMMARY_FALL: operation_fall_filter <= cmd_in.data;
				status_pkg::WR_OPERATION_SUMMARY_RISE: operation_rise_filter <= cmd_in.data;
				status_pkg::WR_QUESTIONABLE_SUMMARY_ENABLE: questionable_summary_event_mask <= cmd_in.data;
				status_pkg::WR_QUESTIONABLE_SUMMARY_FALL: questionable_summary_fall_filter <= cmd_in.data;
				status_pkg::WR_QUESTIONABLE_SUMMARY_RISE: questionable_summary_rise_filter <= cmd_in.data;
				default: ;
			endcase
		end

	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			std_event_mask <= status_pkg::CLEAR_BYTE;
			srq_enable <= status_pkg::CLEAR_BYTE;
		end
		else
		begin
			if (is_cmd(cmd_in, status_pkg::WR_STD_ENABLE))
				std_event_mask <= cmd_in.data[7:0];
			if (is_cmd(cmd_in, status_pkg::WR_SRQ_ENABLE))
				srq_enable <= cmd_in.data[7:0];
		end

	// ------------------------------------------------------------
	// Output queue
	// ------------------------------------------------------------
	assign queue_ready_out = queue_count != status_pkg::QUEUE_FULL;
	assign do_push = queue_push_in && queue_ready_out;
	assign do_pop = is_cmd(cmd_in, status_pkg::RD_QUEUE) && (queue_count != status_pkg::QUEUE_EMPTY);

	always_ff @(posedge clk_in)
		if (do_push)
			queue_mem[queue_tail] <= queue_data_in;

	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			queue_head <= 4'h0;
			queue_tail <= 4'h0;
			queue_count <= status_pkg::QUEUE_EMPTY;
		end
		else
		begin
			if (do_push)
				queue_tail <= queue_tail + 4'h1;
			if (do_pop)
				queue_head <= queue_head + 4'h1;
			if (do_push && !do_pop)
				queue_count <= queue_count + 5'h01;
			else if (do_pop && !do_push)
				queue_count <= queue_count - 5'h01;
		end

	// ------------------------------------------------------------
	// Status byte and service request
	// ------------------------------------------------------------
	// Summaries are combinational so they follow every change at once
	always_comb
	begin
		operation_summary = |(operation_event_latch & operation_event_mask);
		questionable_summary = |(questionable_summary_event_latch & questionable_summary_event_mask);
		std_summary = |(std_event_latch & std_event_mask);
		message_available = queue_count != status_pkg::QUEUE_EMPTY;
		summary_status_byte = status_pkg::CLEAR_BYTE;
		summary_status_byte[status_pkg::STB_OPERATION_SUMMARY] = operation_summary;
		summary_status_byte[status_pkg::STB_QUESTIONABLE_SUMMARY] = questionable_summary;
		summary_status_byte[status_pkg::STB_STD] = std_summary;
		summary_status_byte[status_pkg::STB_MAV] = message_available;
		summary_status_byte[status_pkg::STB_SRQ] = request_service_latched;
		master_summary = |(summary_status_byte & srq_enable &
			~(8'h01 << status_pkg::STB_SRQ));
	end

	// Request only on a new reason for service; the poll clears it
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			request_service_latched <= 1'b0;
			mss_prev <= 1'b0;
		end
		else
		begin
			mss_prev <= master_summary;
			if (master_summary && !mss_prev)
				request_service_latched <= 1'b1;
			else if (serial_poll_in || cls)
				request_service_latched <= 1'b0;
		end

	assign service_request_out = request_service_latched;
	assign status_byte_out = summary_status_byte;

	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			poll_byte_out <= status_pkg::CLEAR_BYTE;
		else if (serial_poll_in)
			poll_byte_out <= summary_status_byte;

	// ------------------------------------------------------------
	// Query responses
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			resp_out <= '0;
		else
		begin
			resp_out.valid <= cmd_in.valid;
			unique case (cmd_in.code)
				status_pkg::RD_OPERATION_SUMMARY_COND: resp_out.data <= operation_condition;
				status_pkg::RD_OPERATION_SUMMARY_EVENT: resp_out.data <= operation_event_latch;
				status_pkg::RD_OPERATION_SUMMARY_ENABLE: resp_out.data <= operation_event_mask;
				status_pkg::RD_OPERATION_SUMMARY_FALL: resp_out.data <= operation_fall_filter;
				status_pkg::RD_OPERATION_SUMMARY_RISE: resp_out.data <= operation_rise_filter;
				status_pkg::RD_QUESTIONABLE_SUMMARY_COND: resp_out.data <= questionable_summary_condition;
				status_pkg::RD_QUESTIONABLE_SUMMARY_EVENT: resp_out.data <= questionable_summary_event_latch;
				status_pkg::RD_QUESTIONABLE_SUMMARY_ENABLE: resp_out.data <= questionable_summary_event_mask;
				status_pkg::RD_QUESTIONABLE_SUMMARY_FALL: resp_out.data <= questionable_summary_fall_filter;
				status_pkg::RD_QUESTIONABLE_SUMMARY_RISE: resp_out.data <= questionable_summary_rise_filter;
				status_pkg::RD_STD_EVENT: resp_out.data <= {8'h00, std_event_latch};
				status_pkg::RD_STD_ENABLE: resp_out.data <= {8'h00, std_event_mask};
				status_pkg::RD_SRQ_ENABLE: resp_out.data <= {8'h00, srq_enable};
				status_pkg::RD_STATUS_BYTE: resp_out.data <= {8'h00, summary_status_byte[7],
					master_summary, summary_status_byte[5:0]};
				status_pkg::RD_QUEUE: resp_out.data <= {8'h00, queue_mem[queue_head] &
					{8{message_available}}};
				default: resp_out.data <= status_pkg::CLEAR_WORD;
			endcase
		end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_operation_summary_summary: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(|(operation_event_latch & operation_event_mask)) == status_byte_out[7])
		else $error("operation summary wrong");
	a_questionable_summary_summary: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(questionable_summary_condition[0]) && questionable_summary_rise_filter[0] && questionable_summary_event_mask[0] |=> status_byte_out[3])
		else $error("questionable summary missed");
	a_mav_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		do_push && queue_count == status_pkg::QUEUE_EMPTY |=> status_byte_out[4])
		else $error("message available not set");
	a_poll_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		serial_poll_in && !(master_summary && !mss_prev) |=> !service_request_out
		&& poll_byte_out[6] == $past(service_request_out))
		else $error("serial poll flag wrong");
	a_stb_query: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		is_cmd(cmd_in, status_pkg::RD_STATUS_BYTE) && !serial_poll_in |=>
		resp_out.data[6] == $past(master_summary) && $stable(service_request_out))
		else $error("status query wrong");
	a_preset_values: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		preset |=> operation_rise_filter == 16'h001F && questionable_summary_rise_filter == 16'h0E3F
		&& operation_event_mask == 16'h0000 && questionable_summary_fall_filter == 16'h0000)
		else $error("preset values wrong");
	a_event_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		is_cmd(cmd_in, status_pkg::RD_OPERATION_SUMMARY_EVENT) && operation_summary_new == 16'h0000 |=>
		resp_out.data == $past(operation_event_latch) && operation_event_latch == 16'h0000)
		else $error("event read did not clear");
	a_rise_latch: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(operation_condition[1]) && operation_rise_filter[1] |=> operation_event_latch[1])
		else $error("rising edge not latched");
	a_ovp_trip: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		over_level |=> output_disable_out ##0 questionable_summary_condition[0])
		else $error("overvoltage not tripped");
	a_clear_status: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		cls && std_event_in == 8'h00 |=> std_event_latch == 8'h00 && !service_request_out)
		else $error("clear status incomplete");

endmodule

// [bench/host_model.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host controller: one-cycle command pulses and serial polls
// ------------------------------------------------------------
module host_model (
	input  wire logic              clk_in,
	input  wire status_pkg::resp_s resp_in,
	output status_pkg::cmd_s       cmd_out,
	output logic                   poll_out
);
	initial
	begin
		cmd_out  = '0;
		poll_out = 1'b0;
	end

	// Called just after a rising edge; waits a bounded time for the answer
	task automatic send(input status_pkg::cmd_e code, input logic [15:0] data, output logic [15:0] rdata);
		int n;
		rdata         = 'x;
		cmd_out.valid = 1'b1;
		cmd_out.code  = code;
		cmd_out.data  = data;
		@(posedge clk_in);
		#1;
		cmd_out.valid = 1'b0;
		// Released data bus shows a changed value, not the old one
		cmd_out.data  = ~data;
		n = 0;
		while (resp_in.valid !== 1'b1 && n < 4)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		if (resp_in.valid === 1'b1)
			rdata = resp_in.data;
		// Idle edge, so back-to-back calls never lower and raise valid in one step
		@(posedge clk_in);
		#1;
	endtask

	task automatic serial_poll();
		poll_out = 1'b1;
		@(posedge clk_in);
		#1;
		poll_out = 1'b0;
	endtask
endmodule

// [bench/instrument_status_reporting_bench.sv]
`timescale 1ns/100ps
module instrument_status_reporting_bench;
	logic                   clk_in;
	logic                   reset_n_in;
	status_pkg::cmd_s       cmd;
	status_pkg::resp_s      resp;
	status_pkg::operation_summary_cond_s operation_summary_cond;
	status_pkg::questionable_summary_cond_s questionable_summary_cond;
	logic [15:0]            voltage;
	logic [7:0]             std_event;
	logic                   push;
	logic [7:0]             push_data;
	logic                   queue_ready;
	logic                   poll;
	logic [7:0]             poll_byte;
	logic                   service_request;
	logic                   output_disable;
	logic [7:0]             status_byte;
	int                     err_total;
	int                     compares;

	instrument_status_reporting instrument_status_reporting_i (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd), .resp_out(resp),
		.operation_summary_cond_in(operation_summary_cond), .questionable_summary_cond_in(questionable_summary_cond), .output_voltage_in(voltage),
		.std_event_in(std_event), .queue_push_in(push), .queue_data_in(push_data),
		.queue_ready_out(queue_ready), .serial_poll_in(poll), .poll_byte_out(poll_byte),
		.service_request_out(service_request), .output_disable_out(output_disable),
		.status_byte_out(status_byte)
	);

	host_model host_model_i (.clk_in(clk_in), .resp_in(resp), .cmd_out(cmd), .poll_out(poll));

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmd_chk(input status_pkg::cmd_e code, input logic [15:0] data, input logic [15:0] exp);
		logic [15:0] got;
		host_model_i.send(code, data, got);
		check(got, exp);
	endtask

	task automatic sb_chk(input logic [7:0] exp);
		check({8'h00, status_byte}, {8'h00, exp});
	endtask

	task automatic results();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic preset_values();
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_RISE, 16'h0000, 16'h001F);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_RISE, 16'h0000, 16'h0E3F);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_FALL, 16'h0000, 16'h0000);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_FALL, 16'h0000, 16'h0000);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_ENABLE, 16'h0000, 16'h0000);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_ENABLE, 16'h0000, 16'h0000);
	endtask

	task automatic filter_edges();
		cmd_chk(status_pkg::WR_OPERATION_SUMMARY_RISE, 16'h0003, 16'h0000);
		cmd_chk(status_pkg::WR_OPERATION_SUMMARY_FALL, 16'h0002, 16'h0000);
		operation_summary_cond = 5'h1F;
		tick(2);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_COND, 16'h0000, 16'h001F);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_EVENT, 16'h0000, 16'h0003);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_EVENT, 16'h0000, 16'h0000);
		operation_summary_cond = 5'h00;
		tick(2);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_EVENT, 16'h0000, 16'h0002);
	endtask

	// Service request, status query, then serial poll, then clear status
	task automatic service_request_flow();
		cmd_chk(status_pkg::WR_OPERATION_SUMMARY_RISE, 16'h0004, 16'h0000);
		operation_summary_cond = 5'h04;
		tick(2);
		sb_chk(8'h00);
		cmd_chk(status_pkg::WR_OPERATION_SUMMARY_ENABLE, 16'h0004, 16'h0000);
		sb_chk(8'h80);
		cmd_chk(status_pkg::WR_SRQ_ENABLE, 16'h0080, 16'h0000);
		tick(1);
		check({15'h0000, service_request}, 16'h0001);
		sb_chk(8'hC0);
		cmd_chk(status_pkg::RD_STATUS_BYTE, 16'h0000, 16'h00C0);
		check({15'h0000, service_request}, 16'h0001);
		host_model_i.serial_poll();
		check({8'h00, poll_byte}, 16'h00C0);
		check({15'h0000, service_request}, 16'h0000);
		sb_chk(8'h80);
		cmd_chk(status_pkg::CLEAR_STATUS, 16'h0000, 16'h0000);
		sb_chk(8'h00);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_EVENT, 16'h0000, 16'h0000);
		cmd_chk(status_pkg::RD_OPERATION_SUMMARY_ENABLE, 16'h0000, 16'h0004);
	endtask

	task automatic questionable_flow();
		cmd_chk(status_pkg::WR_QUESTIONABLE_SUMMARY_RISE, 16'h0000, 16'h0000);
		cmd_chk(status_pkg::WR_QUESTIONABLE_SUMMARY_FALL, 16'h0002, 16'h0000);
		questionable_summary_cond = 8'hE1;
		tick(2);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_COND, 16'h0000, 16'h0E02);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_EVENT, 16'h0000, 16'h0000);
		questionable_summary_cond = 8'h1E;
		tick(2);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_COND, 16'h0000, 16'h003C);
		cmd_chk(status_pkg::WR_QUESTIONABLE_SUMMARY_ENABLE, 16'h0002, 16'h0000);
		sb_chk(8'h08);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_EVENT, 16'h0000, 16'h0002);
		sb_chk(8'h00);
		questionable_summary_cond = 8'h00;
	endtask

	task automatic standard_flow();
		std_event = 8'h62;
		tick(1);
		std_event = 8'h00;
		tick(1);
		sb_chk(8'h00);
		cmd_chk(status_pkg::WR_STD_ENABLE, 16'h0020, 16'h0000);
		sb_chk(8'h20);
		cmd_chk(status_pkg::RD_STD_EVENT, 16'h0000, 16'h0020);
		cmd_chk(status_pkg::RD_STD_EVENT, 16'h0000, 16'h0000);
		sb_chk(8'h00);
	endtask

	task automatic queue_flow();
		check({15'h0000, queue_ready}, 16'h0001);
		push      = 1'b1;
		push_data = 8'hA5;
		tick(1);
		push_data = 8'h3C;
		tick(1);
		push = 1'b0;
		sb_chk(8'h10);
		cmd_chk(status_pkg::RD_QUEUE, 16'h0000, 16'h00A5);
		sb_chk(8'h10);
		cmd_chk(status_pkg::RD_QUEUE, 16'h0000, 16'h003C);
		sb_chk(8'h00);
		// Seventeen pushes: the last one meets a full queue and is dropped
		push = 1'b1;
		for (int i = 0; i < 17; i++)
		begin
			push_data = 8'(i);
			tick(1);
		end
		push = 1'b0;
		check({15'h0000, queue_ready}, 16'h0000);
		for (int i = 0; i < 16; i++)
			cmd_chk(status_pkg::RD_QUEUE, 16'h0000, 16'(i));
		check({15'h0000, queue_ready}, 16'h0001);
		sb_chk(8'h00);
	endtask

	task automatic overvoltage_flow();
		cmd_chk(status_pkg::WR_OVP_LEVEL, 16'h1000, 16'h0000);
		cmd_chk(status_pkg::WR_QUESTIONABLE_SUMMARY_RISE, 16'h0001, 16'h0000);
		cmd_chk(status_pkg::WR_QUESTIONABLE_SUMMARY_ENABLE, 16'h0001, 16'h0000);
		voltage = 16'h1001;
		tick(3);
		check({15'h0000, output_disable}, 16'h0001);
		sb_chk(8'h08);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_COND, 16'h0000, 16'h0001);
		cmd_chk(status_pkg::COUPLED_PROTECTION_FLAG_CLEAR, 16'h0000, 16'h0000);
		check({15'h0000, output_disable}, 16'h0001);
		voltage = 16'h0800;
		tick(2);
		cmd_chk(status_pkg::COUPLED_PROTECTION_FLAG_CLEAR, 16'h0000, 16'h0000);
		tick(1);
		check({15'h0000, output_disable}, 16'h0000);
		cmd_chk(status_pkg::RD_QUESTIONABLE_SUMMARY_EVENT, 16'h0000, 16'h0001);
	endtask

	initial
	begin
		#50000;
		err_total++;
		results();
	end

	initial
	begin
		err_total  = 0;
		compares   = 0;
		reset_n_in = 1'b0;
		operation_summary_cond  = 5'h00;
		questionable_summary_cond  = 8'h00;
		voltage    = 16'h0000;
		std_event  = 8'h00;
		push       = 1'b0;
		push_data  = 8'h00;
		tick(16);
		reset_n_in = 1'b1;
		tick(1);
		sb_chk(8'h00);
		preset_values();
		filter_edges();
		service_request_flow();
		questionable_flow();
		standard_flow();
		queue_flow();
		overvoltage_flow();
		cmd_chk(status_pkg::STATUS_PRESET, 16'h0000, 16'h0000);
		preset_values();
		results();
	end
endmodule
